// file: dv/fal_link_checker.sv
// Concurrent checks on the link between the slice end and its neighbour.
// Assumes one clock, async active-low reset, and a strap held still for long spans.
`default_nettype none

module fal_link_checker (
   input wire logic clock,
   input wire logic rstn,
   input wire logic data_active_low,
   input wire logic [3:0] op_a,
   input wire logic [3:0] op_b,
   input wire logic func_sel_0,
   input wire logic func_sel_1,
   input wire logic func_sel_2,
   input wire logic func_sel_3,
   input wire logic mode,
   input wire logic carry_in,
   input wire logic [3:0] f,
   input wire logic slice_carry_out,
   input wire logic slice_prop_n,
   input wire logic slice_gen_n,
   input wire logic eq_level,
   input wire logic [3:0] la_prop_n,
   input wire logic [3:0] la_gen_n,
   input wire logic la_carry_in,
   input wire logic lookahead_carry_1,
   input wire logic lookahead_carry_2,
   input wire logic lookahead_carry_3,
   input wire logic la_group_prop_n,
   input wire logic la_group_gen_n
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] strap_hist_q;
   logic [3:0] sel;
   logic [3:0] xor_q;
   logic [4:0] add_q, sub_q, dbl_q, la_q;
   logic eq_q;
   logic hi;

   function automatic logic [4:0] chain(input logic [3:0] g_n, p_n, input logic c);
      logic [4:0] r;
      logic k;
      logic z;
      k = c;
      z = 1'b0;
      for (int i = 0; i < 4; i++) begin
         k = !g_n[i] || (!p_n[i] && k);
         z = !g_n[i] || (!p_n[i] && z);
         r[i] = k;
      end
      r[3] = !z;
      r[4] = |p_n;
      return r;
   endfunction

   assign sel = {func_sel_3, func_sel_2, func_sel_1, func_sel_0};
   // Strap must have been still for four edges, else the synchroniser may lag
   assign hi = (strap_hist_q == 4'h0) && !data_active_low;

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         strap_hist_q <= 4'hf;
      end else begin
         strap_hist_q <= {strap_hist_q[2:0], data_active_low};
      end
   end

   always_ff @(posedge clock) begin
      xor_q <= op_a ^ op_b;
      add_q <= {1'b0, op_a} + {1'b0, op_b} + {4'h0, carry_in};
      sub_q <= {1'b0, op_a} + {1'b0, ~op_b} + {4'h0, carry_in};
      dbl_q <= {op_a, carry_in};
      eq_q <= op_a == op_b;
      la_q <= chain(la_gen_n, la_prop_n, la_carry_in);
   end

   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);

   sequence arith_req(logic [3:0] code);
      hi && !mode && sel == code;
   endsequence

   sequence add_nocarry;
      arith_req(4'h9) ##0 !carry_in;
   endsequence

   logic_xor_a: assert property (hi && mode && sel == 4'h6 |=> f == xor_q)
      else $error("logic result wrong");
   add_sum_a: assert property (arith_req(4'h9) |=> {slice_carry_out, f} == add_q)
      else $error("add result wrong");
   sub_diff_a: assert property (arith_req(4'h6) |=> {slice_carry_out, f} == sub_q)
      else $error("subtract result wrong");
   double_shift_a: assert property (arith_req(4'hc) |=> {slice_carry_out, f} == dbl_q)
      else $error("double result wrong");
   equal_out_a: assert property (arith_req(4'h6) ##0 !carry_in |=> eq_level == eq_q)
      else $error("equality wrong");
   group_gen_a: assert property (add_nocarry |=> slice_gen_n == !add_q[4])
      else $error("slice generate wrong");
   group_prop_a: assert property (add_nocarry ##1 !slice_prop_n |-> add_q > 5'h0e)
      else $error("slice propagate wrong");
   la_carries_a: assert property ($past(rstn) |->
      {lookahead_carry_3, lookahead_carry_2, lookahead_carry_1} == la_q[2:0])
      else $error("anticipated carries wrong");
   la_group_a: assert property ($past(rstn) |->
      {la_group_prop_n, la_group_gen_n} == la_q[4:3])
      else $error("group outputs wrong");
endmodule

`default_nettype wire

// file: dv/four_bit_alu_with_carry_lookahead_test.sv
// Bench: both ends joined by the link, driven from the neighbour's user side.
// Assumes results three clocks after a request, look-ahead settled after five.
`default_nettype none

module four_bit_alu_with_carry_lookahead_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TIME_LIMIT = 5000;
   logic clock, rstn, strap, op_mode, op_carry_in, next_slice_carry, upper_prop_n, m, c;
   logic a_gt_b, a_lt_b, a_eq_b;
   logic upper_gen_n, gc_1, gc_2, gc_3, cy, gg;
   logic [2:0] ecar;
   logic [2:0] peer_prop_n, peer_gen_n;
   logic [3:0] op_a, op_b, op_sel, res_f, a, b, sel;
   logic [4:0] e;
   logic [3:0] pairs [6] = '{4'hc, 4'ha, 4'h7, 4'h7, 4'h1, 4'hf};
   int num_errors = 0;
   int total_checks = 0;
   int cycles = 0;

   fal_link_if lk ();
   fal_slice_end fal_slice_end_i (.clock(clock), .rstn(rstn), .data_active_low(strap),
      .link(lk.slice_port));
   fal_peer_end fal_peer_end_i (.clock(clock), .rstn(rstn), .op_a(op_a), .op_b(op_b),
      .op_sel(op_sel), .op_mode(op_mode), .op_carry_in(op_carry_in),
      .peer_prop_n(peer_prop_n), .peer_gen_n(peer_gen_n), .res_f(res_f),
      .next_slice_carry(next_slice_carry), .next_group_carry_1(gc_1),
      .next_group_carry_2(gc_2), .next_group_carry_3(gc_3), .upper_prop_n(upper_prop_n),
      .upper_gen_n(upper_gen_n), .a_gt_b(a_gt_b),
      .a_lt_b(a_lt_b), .a_eq_b(a_eq_b), .link(lk.peer_port));
   fal_link_checker fal_link_checker_i (.clock(clock), .rstn(rstn), .data_active_low(strap),
      .op_a(lk.op_a), .op_b(lk.op_b), .func_sel_0(lk.func_sel_0), .func_sel_1(lk.func_sel_1),
      .func_sel_2(lk.func_sel_2), .func_sel_3(lk.func_sel_3), .mode(lk.mode),
      .carry_in(lk.carry_in), .f(lk.f), .slice_carry_out(lk.slice_carry_out),
      .slice_prop_n(lk.slice_prop_n), .slice_gen_n(lk.slice_gen_n), .eq_level(lk.eq_level),
      .la_prop_n(lk.la_prop_n), .la_gen_n(lk.la_gen_n), .la_carry_in(lk.la_carry_in),
      .lookahead_carry_1(lk.lookahead_carry_1), .lookahead_carry_2(lk.lookahead_carry_2),
      .lookahead_carry_3(lk.lookahead_carry_3), .la_group_prop_n(lk.la_group_prop_n),
      .la_group_gen_n(lk.la_group_gen_n));

   // Active-high model: logic is bitwise, arithmetic is first term plus second plus carry
   function automatic logic [4:0] alu_exp(input logic [3:0] a, b, s, input logic m, c);
      logic [3:0] x;
      logic [3:0] y;
      x = a | (b & {4{s[0]}}) | (~b & {4{s[1]}});
      y = (a & ~b & {4{s[2]}}) | (a & b & {4{s[3]}});
      if (m) return {1'b0, ~(x ^ y)};
      return {1'b0, x} + {1'b0, y} + {4'h0, c};
   endfunction

   task automatic check(input logic [4:0] got, input logic [4:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic request(input logic [3:0] ra, rb, rs, input logic rm, rc, input int waits);
      {op_a, op_b, op_sel, op_mode, op_carry_in} = {ra, rb, rs, rm, rc};
      repeat (waits) @(posedge clock);
      #1;
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   always @(posedge clock) begin
      cycles++;
      if (cycles == TIME_LIMIT) begin
         num_errors++;
         $display("MISMATCH %0t run too long", $time);
         summarize();
      end
   end

   initial begin
      {rstn, strap, op_a, op_b, op_sel, op_mode, op_carry_in, peer_prop_n, peer_gen_n} = '0;
      repeat (6) @(posedge clock);
      #1;
      rstn = 1'b1;
      // Every mode, select and carry, in both data conventions
      for (int s = 0; s < 2; s++) begin
         strap = s[0];
         repeat (4) @(posedge clock);
         #1;
         for (int i = 0; i < 192; i++) begin
            c = i[0];
            m = i >= 96;
            sel = 4'(i / 6);
            a = pairs[(i / 2) % 3 * 2];
            b = pairs[(i / 2) % 3 * 2 + 1];
            e = s[0] ? ~alu_exp(~a, ~b, sel, m, !c) : alu_exp(a, b, sel, m, c);
            request(a, b, sel, m, c, 3);
            check({!m & next_slice_carry, res_f}, {!m & e[4], e[3:0]});
            if (s == 0) begin
               e = (!m && sel == 4'h6 && !c) ? {2'h0, a > b, a < b, a == b} : 5'h00;
               check({2'h0, a_gt_b, a_lt_b, a_eq_b}, e);
            end
         end
      end
      // Slice as group 0 beside every pattern of the three upper groups
      strap = 1'b0;
      for (int k = 0; k < 256; k++) begin
         {peer_gen_n, peer_prop_n} = k[5:0];
         request(k[6] ? 4'hf : 4'h0, 4'h0, 4'h9, 1'b0, k[7], 5);
         check({4'h0, upper_prop_n}, {4'h0, |{peer_prop_n, !k[6]}});
         cy = k[6] & k[7];
         gg = 1'b0;
         for (int j = 0; j < 3; j++) begin
            ecar[j] = cy;
            cy = !peer_gen_n[j] | (!peer_prop_n[j] & cy);
            gg = !peer_gen_n[j] | (!peer_prop_n[j] & gg);
         end
         check({2'h0, gc_3, gc_2, gc_1}, {2'h0, ecar});
         check({4'h0, upper_gen_n}, {4'h0, !gg});
      end
      summarize();
   end
endmodule

`default_nettype wire

// file: hw/fal_link_if.sv
// Link between the slice end and its neighbouring logic.
// Assumes both ends share one clock; the equality line is an open-drain
// wire with a pull-up, resolved here from the drivers' enables.
`default_nettype none

interface fal_link_if;
   // Operand and function request, neighbour to slice
   logic [3:0] op_a;
   logic [3:0] op_b;
   logic func_sel_0;
   logic func_sel_1;
   logic func_sel_2;
   logic func_sel_3;
   logic mode;
   logic carry_in;
   // Slice results
   logic [3:0] f;
   logic slice_carry_out;
   logic slice_prop_n;
   logic slice_gen_n;
   logic eq_o;
   logic eq_oe;
   logic eq_level;
   // Look-ahead unit inputs and results
   logic [3:0] la_prop_n;
   logic [3:0] la_gen_n;
   logic la_carry_in;
   logic lookahead_carry_1;
   logic lookahead_carry_2;
   logic lookahead_carry_3;
   logic la_group_prop_n;
   logic la_group_gen_n;

   // Pulled up unless a driver pulls low
   assign eq_level = !(eq_oe && !eq_o);

   modport slice_port (
      input op_a, op_b, func_sel_0, func_sel_1, func_sel_2, func_sel_3,
      input mode, carry_in, la_prop_n, la_gen_n, la_carry_in,
      output f, slice_carry_out, slice_prop_n, slice_gen_n, eq_o, eq_oe,
      output lookahead_carry_1, lookahead_carry_2, lookahead_carry_3,
      output la_group_prop_n, la_group_gen_n
   );

   modport peer_port (
      output op_a, op_b, func_sel_0, func_sel_1, func_sel_2, func_sel_3,
      output mode, carry_in, la_prop_n, la_gen_n, la_carry_in,
      input f, slice_carry_out, slice_prop_n, slice_gen_n, eq_level,
      input lookahead_carry_1, lookahead_carry_2, lookahead_carry_3,
      input la_group_prop_n, la_group_gen_n
   );
endinterface

`default_nettype wire

// file: hw/fal_peer_end.sv
// Neighbour end: drives one slice and its look-ahead unit, chains the
// carries onward and forms the magnitude comparison.
// Assumes user inputs are on this clock; results three clocks after request.
`default_nettype none

module fal_peer_end (
   input wire logic clock,
   input wire logic rstn,
   input wire logic [3:0] op_a,
   input wire logic [3:0] op_b,
   input wire logic [3:0] op_sel,
   input wire logic op_mode,
   input wire logic op_carry_in,
   input wire logic [2:0] peer_prop_n,
   input wire logic [2:0] peer_gen_n,
   output logic [3:0] res_f,
   output logic next_slice_carry,
   output logic next_group_carry_1,
   output logic next_group_carry_2,
   output logic next_group_carry_3,
   output logic upper_prop_n,
   output logic upper_gen_n,
   output logic a_gt_b,
   output logic a_lt_b,
   output logic a_eq_b,
   fal_link_if.peer_port link
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   fal_pkg::fal_host_state_type s_q;
   fal_pkg::fal_host_state_type s_d;

   logic is_cmp;

   always_comb begin
      s_d = s_q;
      s_d.a = op_a;
      s_d.b = op_b;
      s_d.sel = op_sel;
      s_d.mode = op_mode;
      s_d.cin = op_carry_in;
      s_d.peer_prop_n = peer_prop_n;
      s_d.peer_gen_n = peer_gen_n;
      // Comparison only meaningful for subtract with no carry in
      is_cmp = (op_mode == fal_pkg::FAL_MODE_ARITH) && (op_sel == fal_pkg::FAL_SEL_SUB) &&
         !op_carry_in;
      s_d.cmp1 = is_cmp;
      s_d.cmp2 = s_q.cmp1;

      s_d.f = link.f;
      s_d.carry_out = link.slice_carry_out;
      s_d.c1 = link.lookahead_carry_1;
      s_d.c2 = link.lookahead_carry_2;
      s_d.c3 = link.lookahead_carry_3;
      s_d.up_prop_n = link.la_group_prop_n;
      s_d.up_gen_n = link.la_group_gen_n;
      // A-B-1 carries out only when A exceeds B
      s_d.eq = s_q.cmp2 && link.eq_level;
      s_d.gt = s_q.cmp2 && link.slice_carry_out;
      s_d.lt = s_q.cmp2 && !link.slice_carry_out && !link.eq_level;
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // ------------------------------------------------------------
   // Link drive
   // ------------------------------------------------------------
   assign link.op_a = s_q.a;
   assign link.op_b = s_q.b;
   assign link.func_sel_0 = s_q.sel[0];
   assign link.func_sel_1 = s_q.sel[1];
   assign link.func_sel_2 = s_q.sel[2];
   assign link.func_sel_3 = s_q.sel[3];
   assign link.mode = s_q.mode;
   assign link.carry_in = s_q.cin;
   // This slice is the lowest group of the look-ahead unit
   assign link.la_prop_n = {s_q.peer_prop_n, link.slice_prop_n};
   assign link.la_gen_n = {s_q.peer_gen_n, link.slice_gen_n};
   assign link.la_carry_in = s_q.cin;

   // ------------------------------------------------------------
   // User side
   // ------------------------------------------------------------
   assign res_f = s_q.f;
   assign next_slice_carry = s_q.carry_out;
   assign next_group_carry_1 = s_q.c1;
   assign next_group_carry_2 = s_q.c2;
   assign next_group_carry_3 = s_q.c3;
   assign upper_prop_n = s_q.up_prop_n;
   assign upper_gen_n = s_q.up_gen_n;
   assign a_gt_b = s_q.gt;
   assign a_lt_b = s_q.lt;
   assign a_eq_b = s_q.eq;

endmodule

`default_nettype wire

// file: hw/fal_pkg.sv
// Shared constants and state types for the four-bit slice and its neighbour.
// Assumes both ends run on one clock and meet through fal_link_if.
`default_nettype none

package fal_pkg;

   // ------------------------------------------------------------
   // Widths
   // ------------------------------------------------------------
   localparam int FAL_WIDTH = 4;
   localparam int FAL_GROUPS = 4;

   // ------------------------------------------------------------
   // Function select codes (active-high data, arithmetic mode)
   // ------------------------------------------------------------
   localparam logic [3:0] FAL_SEL_ADD = 4'h9;
   localparam logic [3:0] FAL_SEL_SUB = 4'h6;
   localparam logic [3:0] FAL_SEL_DOUBLE = 4'hc;

   // ------------------------------------------------------------
   // Mode levels
   // ------------------------------------------------------------
   localparam logic FAL_MODE_LOGIC = 1'b1;
   localparam logic FAL_MODE_ARITH = 1'b0;

   // ------------------------------------------------------------
   // Timing in clock cycles
   // ------------------------------------------------------------
   localparam int FAL_DEV_LATENCY = 1;
   localparam int FAL_HOST_LATENCY = 3;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [3:0] FAL_RESET_WORD = 4'h0;
   localparam logic FAL_RESET_BIT = 1'b0;
   localparam logic FAL_RESET_BIT_N = 1'b1;

   // ------------------------------------------------------------
   // State types
   // ------------------------------------------------------------
   typedef struct packed {
      logic pol_meta;
      logic pol_sync;
      logic [3:0] f;
      logic carry_out;
      logic prop_n;
      logic gen_n;
      logic equal;
      logic la_c1;
      logic la_c2;
      logic la_c3;
      logic la_prop_n;
      logic la_gen_n;
   } fal_dev_state_type;

   typedef struct packed {
      logic [3:0] a;
      logic [3:0] b;
      logic [3:0] sel;
      logic mode;
      logic cin;
      logic [2:0] peer_prop_n;
      logic [2:0] peer_gen_n;
      logic cmp1;
      logic cmp2;
      logic [3:0] f;
      logic carry_out;
      logic c1;
      logic c2;
      logic c3;
      logic up_prop_n;
      logic up_gen_n;
      logic gt;
      logic lt;
      logic eq;
   } fal_host_state_type;

endpackage

`default_nettype wire

// file: hw/fal_slice_end.sv
// Slice end: four-bit logic/arithmetic slice plus its carry look-ahead unit.
// Assumes the neighbour drives the link from flops on the same clock;
// results appear registered one clock after the request.
// Limitation: that register stage means a ripple chain of slices built
// from this end gains one clock per slice, not one gate delay.
//
// How it works
// - Logic mode: bitwise function, no carries
// - Arithmetic mode: four-bit words, carries ripple
// - Sixteen functions each; either data polarity
// - Active carry input adds one
// - A plus A shifts bits up
// - Carry-out from top bit chains onward
// - Subtract via ones complement: A-B-1
// - Open-drain equality, high when equal
// - Neighbour derives greater/less from equality, carry
// - Active-low group propagate and generate outputs
// - One look-ahead unit per four slices
// - Look-ahead takes four low pairs, carry
// - Three anticipated carries, one per upper group
// - Look-ahead gives active-low group outputs
// - Look-ahead units cascade in levels
`default_nettype none

module fal_slice_end (
   input wire logic clock,
   input wire logic rstn,
   input wire logic data_active_low,
   fal_link_if.slice_port link
);

   // ------------------------------------------------------------
   // Carry arithmetic shared by slice and look-ahead
   // ------------------------------------------------------------

   // The carry helpers take active-high terms; callers invert the pins
   // Carry into each position plus the carry out of the top
   function automatic logic [4:0] fal_chain(
      input logic [3:0] g,
      input logic [3:0] p,
      input logic c
   );
      logic [4:0] cc;
      cc = {4'h0, c};
      for (int i = 0; i < 4; i++) begin
         cc[i + 1] = g[i] | (p[i] & cc[i]);
      end
      return cc;
   endfunction

   // Group generate: top generate, or lower one passed by all above
   function automatic logic fal_group_gen(
      input logic [3:0] g,
      input logic [3:0] p
   );
      return g[3] | (p[3] & g[2]) | (p[3] & p[2] & g[1]) |
         (p[3] & p[2] & p[1] & g[0]);
   endfunction

   // Group propagate: every position passes a carry
   function automatic logic fal_group_prop(
      input logic [3:0] p
   );
      return &p;
   endfunction

   // Data polarity: active-low words are handled by inverting them
   function automatic logic [3:0] fal_flip(
      input logic [3:0] v,
      input logic inv
   );
      return v ^ {4{inv}};
   endfunction

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   fal_pkg::fal_dev_state_type s_q;
   fal_pkg::fal_dev_state_type s_d;

   // Reset releases every active-low output and clears every carry
   localparam fal_pkg::fal_dev_state_type FAL_DEV_RESET = '{
      pol_meta: fal_pkg::FAL_RESET_BIT,
      pol_sync: fal_pkg::FAL_RESET_BIT,
      f: fal_pkg::FAL_RESET_WORD,
      carry_out: fal_pkg::FAL_RESET_BIT,
      prop_n: fal_pkg::FAL_RESET_BIT_N,
      gen_n: fal_pkg::FAL_RESET_BIT_N,
      equal: fal_pkg::FAL_RESET_BIT,
      la_c1: fal_pkg::FAL_RESET_BIT,
      la_c2: fal_pkg::FAL_RESET_BIT,
      la_c3: fal_pkg::FAL_RESET_BIT,
      la_prop_n: fal_pkg::FAL_RESET_BIT_N,
      la_gen_n: fal_pkg::FAL_RESET_BIT_N
   };

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   // Scratch terms, all fully assigned each pass
   logic [3:0] sel;
   logic [3:0] a;
   logic [3:0] b;
   logic cin;
   logic [3:0] ip;
   logic [3:0] ig;
   logic [3:0] half;
   logic [4:0] c;
   logic [3:0] fi;
   logic [3:0] lp;
   logic [3:0] lg;
   logic [4:0] lc;

   always_comb begin
      s_d = s_q;

      // ------------------------------------------------------------
      // Strap synchroniser
      // ------------------------------------------------------------
      // Polarity strap comes from a pin: two flops before use
      s_d.pol_meta = data_active_low;
      s_d.pol_sync = s_q.pol_meta;

      // ------------------------------------------------------------
      // Operands
      // ------------------------------------------------------------
      sel = {link.func_sel_3, link.func_sel_2, link.func_sel_1, link.func_sel_0};
      // The slice is self-dual: inverting every data line and the carry
      // turns the active-high table into the active-low one.
      a = fal_flip(link.op_a, s_q.pol_sync);
      b = fal_flip(link.op_b, s_q.pol_sync);
      cin = link.carry_in ^ s_q.pol_sync;

      // ------------------------------------------------------------
      // Slice result
      // ------------------------------------------------------------
      // Per-bit terms chosen by the select code; with code 0110 the B
      // term enters inverted, which is the ones-complement subtrahend.
      ip = ~(a | (b & {4{sel[0]}}) | (~b & {4{sel[1]}}));
      ig = ~((a & ~b & {4{sel[2]}}) | (a & b & {4{sel[3]}}));
      half = ip ^ ig;

      // Generate is ~ig, propagate is ~ip; carry enters at bit zero
      c = fal_chain(~ig, ~ip, cin);

      // Logic mode forces the carry term high, so no bit sees its neighbour
      for (int i = 0; i < 4; i++) begin
         fi[i] = half[i] ^ (link.mode | c[i]);
      end
      s_d.f = fal_flip(fi, s_q.pol_sync);
      s_d.carry_out = c[4] ^ s_q.pol_sync;

      // ------------------------------------------------------------
      // Equality and group terms
      // ------------------------------------------------------------
      // Equal words give all ones in subtract mode with no carry in
      s_d.equal = &fi;
      // Group terms ignore the strap: they describe the internal sum
      s_d.gen_n = ~fal_group_gen(~ig, ~ip);
      s_d.prop_n = ~fal_group_prop(~ip);

      // ------------------------------------------------------------
      // Look-ahead unit
      // ------------------------------------------------------------
      // Look-ahead unit: active-low pairs, active-high carry
      lp = ~link.la_prop_n;
      lg = ~link.la_gen_n;
      lc = fal_chain(lg, lp, link.la_carry_in);
      s_d.la_c1 = lc[1];
      s_d.la_c2 = lc[2];
      s_d.la_c3 = lc[3];
      s_d.la_gen_n = ~fal_group_gen(lg, lp);
      s_d.la_prop_n = ~fal_group_prop(lp);
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   // One register stage keeps every link path one cycle; the strap passes two flops first
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         s_q <= FAL_DEV_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   // Every output but the tied-low eq_o comes from a flop, so the neighbour sees no glitch
   assign link.f = s_q.f;
   assign link.slice_carry_out = s_q.carry_out;
   assign link.slice_prop_n = s_q.prop_n;
   assign link.slice_gen_n = s_q.gen_n;
   // Open drain: only ever pulls low, released when every result bit is one
   assign link.eq_o = 1'b0;
   assign link.eq_oe = !s_q.equal;
   assign link.lookahead_carry_1 = s_q.la_c1;
   assign link.lookahead_carry_2 = s_q.la_c2;
   assign link.lookahead_carry_3 = s_q.la_c3;
   assign link.la_group_prop_n = s_q.la_prop_n;
   assign link.la_group_gen_n = s_q.la_gen_n;

endmodule

`default_nettype wire
